/* File: src/acr_pkg.sv */
// Constants, register map and helpers for the converter control block
package acr_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ACR_ADDR_STATUS_CONTROL_ONE     = 3'h0;
    localparam logic [2:0] ACR_ADDR_STATUS_CONTROL_TWO     = 3'h1;
    localparam logic [2:0] ACR_ADDR_RESULT_HIGH            = 3'h2;
    localparam logic [2:0] ACR_ADDR_RESULT_LOW             = 3'h3;
    localparam logic [2:0] ACR_ADDR_COMPARE_VALUE_HIGH     = 3'h4;
    localparam logic [2:0] ACR_ADDR_COMPARE_VALUE_LOW      = 3'h5;
    localparam logic [2:0] ACR_ADDR_CONVERTER_CONFIGURATION = 3'h6;

    // Field positions
    localparam int ACR_SC1_COMPLETE_BIT   = 7;
    localparam int ACR_SC1_IRQ_EN_BIT     = 6;
    localparam int ACR_SC1_CONTINUOUS_BIT = 5;
    localparam int ACR_SC2_ACTIVE_BIT     = 7;
    localparam int ACR_SC2_TRIGGER_BIT    = 6;
    localparam int ACR_SC2_CMP_EN_BIT     = 5;
    localparam int ACR_SC2_CMP_DIR_BIT    = 4;
    localparam int ACR_CFG_LOW_POWER_BIT  = 7;
    localparam int ACR_CFG_DIV_MSB        = 6;
    localparam int ACR_CFG_DIV_LSB        = 5;
    localparam int ACR_CFG_LONG_SMP_BIT   = 4;
    localparam int ACR_CFG_MODE_MSB       = 3;
    localparam int ACR_CFG_MODE_LSB       = 2;
    localparam int ACR_CFG_CLK_MSB        = 1;
    localparam int ACR_CFG_CLK_LSB        = 0;

    // Reset values and codes
    localparam logic [7:0] ACR_RST_BYTE        = 8'h00;
    localparam logic [4:0] ACR_RST_CHANNEL     = 5'h1F;
    localparam logic [4:0] ACR_CHANNEL_OFF     = 5'h1F;
    localparam logic [1:0] ACR_MODE_TEN_BIT    = 2'h2;
    localparam logic [1:0] ACR_CLK_BUS         = 2'h0;
    localparam logic [1:0] ACR_CLK_BUS_HALF    = 2'h1;
    localparam logic [1:0] ACR_CLK_ALTERNATE   = 2'h2;
    localparam logic [1:0] ACR_CLK_ASYNC       = 2'h3;

    // Conversion timing in conversion clock ticks
    localparam logic [5:0] ACR_SHORT_SAMPLE_TICKS = 6'h04;
    localparam logic [5:0] ACR_LONG_SAMPLE_TICKS  = 6'h18;
    localparam logic [5:0] ACR_BITS_EIGHT         = 6'h08;
    localparam logic [5:0] ACR_BITS_TEN           = 6'h0A;

    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_SAMPLE,
        ACR_CONVERT
    } acr_state_t;

    // Mode code to ten-bit selection; reserved codes act as eight-bit
    function automatic logic acr_is_ten_bit(input logic [1:0] mode);
        return mode == ACR_MODE_TEN_BIT;
    endfunction

    // Divider code to last count value (ratio minus one)
    function automatic logic [2:0] acr_div_last(input logic [1:0] code);
        return 3'((4'h1 << code) - 4'h1);
    endfunction

endpackage

/* File: src/acr_conv_clock.sv */
// Conversion clock tick generator: source select and divider
`timescale 1ns/1ps
module acr_conv_clock
    import acr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [1:0] input_clock_field,
    input  wire logic [1:0] clock_divider_field,
    input  wire logic       alternate_clock,
    input  wire logic       internal_async_clock,
    output logic            conv_tick
);

    logic       half_q;
    logic       alt_q;
    logic       async_q;
    logic [2:0] div_cnt_q;
    logic       src_tick;

    ////////////////////////////////////////////////////////////////////
    // Source select
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            half_q  <= 1'b0;
            alt_q   <= 1'b0;
            async_q <= 1'b0;
        end else begin
            half_q  <= ~half_q;
            alt_q   <= alternate_clock;
            async_q <= internal_async_clock;
        end
    end

    always_comb begin
        unique case (input_clock_field)
            ACR_CLK_BUS:       src_tick = 1'b1;
            ACR_CLK_BUS_HALF:  src_tick = half_q;
            ACR_CLK_ALTERNATE: src_tick = alternate_clock & ~alt_q;
            ACR_CLK_ASYNC:     src_tick = internal_async_clock & ~async_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Divider
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt_q <= 3'h0;
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= 1'b0;
            if (src_tick) begin
                if (div_cnt_q >= acr_div_last(clock_divider_field)) begin
                    div_cnt_q <= 3'h0;
                    conv_tick <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 3'h1;
                end
            end
        end
    end

endmodule

/* File: src/acr_top.sv */
// Converter control: registers, triggers, sequencer, compare and results
//
// Behaviour
// - Active flag is set at conversion start, cleared at completion or abort.
// - Trigger select picks software write or hardware trigger as start source.
// - Compare enable bit turns the automatic compare on or off.
// - Direction 0 means result below value; 1 means result at or above.
// - Result high holds upper two bits; reads zero in eight-bit mode.
// - Results load at each completion unless compare is on and fails.
// - Ten-bit: high read blocks result loads until low is read.
// - Eight-bit: no interlock, every completed result that passes an enabled compare is transferred.
// - After a mode change results are invalid until the next completion.
// - Result low holds lower eight bits, or the whole eight-bit result.
// - Compare high bits take part only in ten-bit mode.
// - Compare low bits always take part in the compare.
// - Configuration bit 7 selects high speed or low power.
// - Divider field divides the input clock by 1, 2, 4 or 8.
// - Configuration bit 4 selects short or long sample time.
// - Mode field: 00 eight-bit, 10 ten-bit, others reserved.
// - Input clock field selects bus, half bus, alternate or async clock.
// - Complete flag set on completion or true compare; cleared by access.
// - Control one write aborts; with software trigger it restarts unless channel is all ones.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic       hardware_trigger_input,
    input  wire logic       alternate_clock,
    input  wire logic       internal_async_clock,
    input  wire logic [9:0] ana_result,
    output logic            ana_enable,
    output logic            ana_sampling,
    output logic      [4:0] ana_channel,
    output logic            ana_long_sample,
    output logic            ana_low_power,
    output logic            ana_ten_bit,
    output logic            ana_clock_tick
);

    logic       complete_q;
    logic       irq_en_q;
    logic       continuous_q;
    logic [4:0] channel_q;
    logic       trigger_select_q;
    logic       compare_enable_q;
    logic       compare_direction_q;
    logic [1:0] cmp_high_q;
    logic [7:0] cmp_low_q;
    logic [7:0] config_q;
    logic [1:0] res_high_q;
    logic [7:0] res_low_q;
    logic       lock_q;
    logic [2:0] trig_sync_q;
    acr_state_t state_q;
    logic [5:0] tick_cnt_q;

    logic       ten_bit;
    logic       sc1_wr;
    logic       sw_start;
    logic       trig_edge;
    logic       hw_start;
    logic       done;
    logic       restart;
    logic [9:0] cur_result;
    logic [9:0] cur_value;
    logic       cmp_true;
    logic       accept;
    logic [5:0] sample_last;
    logic [5:0] bits_last;
    logic       read_low;
    logic       read_high;

    ////////////////////////////////////////////////////////////////////
    // Decode
    assign ten_bit   = acr_is_ten_bit(
                           config_q[ACR_CFG_MODE_MSB:ACR_CFG_MODE_LSB]);
    assign sc1_wr    = bus_wr && bus_addr == ACR_ADDR_STATUS_CONTROL_ONE;
    assign read_low  = bus_rd && bus_addr == ACR_ADDR_RESULT_LOW;
    assign read_high = bus_rd && bus_addr == ACR_ADDR_RESULT_HIGH;
    assign sw_start  = sc1_wr && !trigger_select_q
                       && bus_wdata[4:0] != ACR_CHANNEL_OFF;
    assign trig_edge = trig_sync_q[1] && !trig_sync_q[2];
    assign hw_start  = trig_edge && trigger_select_q && !sc1_wr
                       && state_q == ACR_IDLE
                       && channel_q != ACR_CHANNEL_OFF;
    assign sample_last = (config_q[ACR_CFG_LONG_SMP_BIT]
                          ? ACR_LONG_SAMPLE_TICKS
                          : ACR_SHORT_SAMPLE_TICKS) - 6'h01;
    assign bits_last = (ten_bit ? ACR_BITS_TEN : ACR_BITS_EIGHT) - 6'h01;
    assign done      = state_q == ACR_CONVERT && ana_clock_tick
                       && tick_cnt_q == bits_last && !sc1_wr;
    assign restart   = continuous_q && channel_q != ACR_CHANNEL_OFF;

    ////////////////////////////////////////////////////////////////////
    // Compare
    assign cur_result = ten_bit ? ana_result
                                : {2'b00, ana_result[7:0]};
    assign cur_value  = ten_bit ? {cmp_high_q, cmp_low_q}
                                : {2'b00, cmp_low_q};
    assign cmp_true   = compare_direction_q
                        ? (cur_result >= cur_value)
                        : (cur_result < cur_value);
    assign accept     = !compare_enable_q || cmp_true;

    ////////////////////////////////////////////////////////////////////
    // Hardware trigger synchroniser
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trig_sync_q <= 3'h0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], hardware_trigger_input};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Writable registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_en_q            <= 1'b0;
            continuous_q        <= 1'b0;
            channel_q           <= ACR_RST_CHANNEL;
            trigger_select_q    <= 1'b0;
            compare_enable_q    <= 1'b0;
            compare_direction_q <= 1'b0;
            cmp_high_q          <= 2'b00;
            cmp_low_q           <= ACR_RST_BYTE;
            config_q            <= ACR_RST_BYTE;
        end else if (bus_wr) begin
            unique case (bus_addr)
                ACR_ADDR_STATUS_CONTROL_ONE: begin
                    irq_en_q     <= bus_wdata[ACR_SC1_IRQ_EN_BIT];
                    continuous_q <= bus_wdata[ACR_SC1_CONTINUOUS_BIT];
                    channel_q    <= bus_wdata[4:0];
                end
                ACR_ADDR_STATUS_CONTROL_TWO: begin
                    trigger_select_q    <= bus_wdata[ACR_SC2_TRIGGER_BIT];
                    compare_enable_q    <= bus_wdata[ACR_SC2_CMP_EN_BIT];
                    compare_direction_q <= bus_wdata[ACR_SC2_CMP_DIR_BIT];
                end
                ACR_ADDR_COMPARE_VALUE_HIGH: begin
                    cmp_high_q <= bus_wdata[1:0];
                end
                ACR_ADDR_COMPARE_VALUE_LOW: begin
                    cmp_low_q <= bus_wdata;
                end
                ACR_ADDR_CONVERTER_CONFIGURATION: begin
                    config_q <= bus_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q      <= ACR_IDLE;
            tick_cnt_q   <= 6'h00;
            ana_enable   <= 1'b0;
            ana_sampling <= 1'b0;
        end else if (sc1_wr) begin
            tick_cnt_q   <= 6'h00;
            state_q      <= sw_start ? ACR_SAMPLE : ACR_IDLE;
            ana_enable   <= sw_start;
            ana_sampling <= sw_start;
        end else if (hw_start) begin
            tick_cnt_q   <= 6'h00;
            state_q      <= ACR_SAMPLE;
            ana_enable   <= 1'b1;
            ana_sampling <= 1'b1;
        end else if (ana_clock_tick) begin
            unique case (state_q)
                ACR_IDLE: begin
                end
                ACR_SAMPLE: begin
                    if (tick_cnt_q >= sample_last) begin
                        tick_cnt_q   <= 6'h00;
                        state_q      <= ACR_CONVERT;
                        ana_sampling <= 1'b0;
                    end else begin
                        tick_cnt_q <= tick_cnt_q + 6'h01;
                    end
                end
                ACR_CONVERT: begin
                    tick_cnt_q <= tick_cnt_q + 6'h01;
                    if (done) begin
                        tick_cnt_q   <= 6'h00;
                        state_q      <= restart ? ACR_SAMPLE : ACR_IDLE;
                        ana_enable   <= restart;
                        ana_sampling <= restart;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Results, interlock and complete flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            res_high_q <= 2'b00;
            res_low_q  <= ACR_RST_BYTE;
        end else if (done && accept && !lock_q) begin
            res_high_q <= cur_result[9:8];
            res_low_q  <= cur_result[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lock_q <= 1'b0;
        end else if (read_low || !ten_bit) begin
            lock_q <= 1'b0;
        end else if (read_high) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            complete_q <= 1'b0;
        end else if (done && accept) begin
            complete_q <= 1'b1;
        end else if (sc1_wr || read_low) begin
            complete_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port and analog side outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata <= ACR_RST_BYTE;
        end else if (bus_rd) begin
            unique case (bus_addr)
                ACR_ADDR_STATUS_CONTROL_ONE:
                    bus_rdata <= {complete_q, irq_en_q, continuous_q,
                                  channel_q};
                ACR_ADDR_STATUS_CONTROL_TWO:
                    bus_rdata <= {ana_enable, trigger_select_q,
                                  compare_enable_q, compare_direction_q,
                                  4'h0};
                ACR_ADDR_RESULT_HIGH:
                    bus_rdata <= {6'h00,
                                  ten_bit ? res_high_q : 2'b00};
                ACR_ADDR_RESULT_LOW:
                    bus_rdata <= res_low_q;
                ACR_ADDR_COMPARE_VALUE_HIGH:
                    bus_rdata <= {6'h00, cmp_high_q};
                ACR_ADDR_COMPARE_VALUE_LOW:
                    bus_rdata <= cmp_low_q;
                ACR_ADDR_CONVERTER_CONFIGURATION:
                    bus_rdata <= config_q;
                default:
                    bus_rdata <= ACR_RST_BYTE;
            endcase
        end else begin
            bus_rdata <= ACR_RST_BYTE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ana_channel     <= ACR_RST_CHANNEL;
            ana_long_sample <= 1'b0;
            ana_low_power   <= 1'b0;
            ana_ten_bit     <= 1'b0;
        end else begin
            ana_channel     <= channel_q;
            ana_long_sample <= config_q[ACR_CFG_LONG_SMP_BIT];
            ana_low_power   <= config_q[ACR_CFG_LOW_POWER_BIT];
            ana_ten_bit     <= ten_bit;
        end
    end

    acr_conv_clock u_conv_clock (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .input_clock_field    (config_q[ACR_CFG_CLK_MSB:ACR_CFG_CLK_LSB]),
        .clock_divider_field  (config_q[ACR_CFG_DIV_MSB:ACR_CFG_DIV_LSB]),
        .alternate_clock      (alternate_clock),
        .internal_async_clock (internal_async_clock),
        .conv_tick            (ana_clock_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking acr_cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_SW_START: assert property (
        sw_start |=> ana_enable && ana_sampling)
        else $error("software start did not raise active");

    AST_DONE_IDLE: assert property (
        done && !restart |=> !ana_enable)
        else $error("active stayed high after completion");

    AST_HW_IGNORES_WRITE: assert property (
        sc1_wr && trigger_select_q |=> !ana_enable)
        else $error("write started conversion in hardware trigger mode");

    AST_HW_START: assert property (
        hw_start |=> ana_enable ##1 !trig_edge)
        else $error("hardware edge did not start exactly once");

    AST_CMP_HOLD: assert property (
        done && compare_enable_q && !cmp_true
        |=> $stable(res_low_q) && $stable(res_high_q) && !$rose(complete_q))
        else $error("failed compare changed results");

    AST_LESS_LOAD: assert property (
        done && compare_enable_q && !compare_direction_q && !ten_bit
        && !lock_q && ana_result[7:0] < cmp_low_q
        |=> res_low_q == $past(ana_result[7:0]) && complete_q)
        else $error("true less-than compare did not load");

    AST_HIGH_ZERO: assert property (
        read_high && !ten_bit |=> bus_rdata == 8'h00)
        else $error("result high nonzero in eight-bit mode");

    AST_LOCK_HOLD: assert property (
        read_high && ten_bit && !read_low ##1 (!read_low)[*2]
        |-> $stable(res_low_q))
        else $error("result changed while interlocked");

    AST_COMPLETE_CLEAR: assert property (
        read_low && !done |=> !complete_q)
        else $error("complete flag not cleared by low read");

    AST_TEN_LOAD: assert property (
        done && !compare_enable_q && !lock_q && ten_bit
        |=> {res_high_q, res_low_q} == $past(ana_result))
        else $error("ten-bit result not loaded");

    COV_HW_CONVERSION: cover property (hw_start ##[1:1000] done);
    COV_CMP_REJECT: cover property (done && compare_enable_q && !cmp_true);
    COV_LOCK_DISCARD: cover property (done && lock_q);
    COV_ABORT: cover property (sc1_wr && state_q == ACR_CONVERT);

endmodule

/* File: sim/acr_ana_model.sv */
// Converter stand-in: gives a set result while a conversion runs
`timescale 1ns/1ps
module acr_ana_model (
    input  wire logic       sys_clk,
    input  wire logic       ana_enable,
    input  wire logic [9:0] set_value,
    output logic      [9:0] ana_result
);
    logic [9:0] last_q = 10'h000;

    always @(posedge sys_clk) begin
        last_q <= ana_result;
    end

    // Idle result line toggles every cycle so a stale sample shows up
    assign ana_result = ana_enable ? set_value : ~last_q;
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
    import acr_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] bus_addr = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic       hw_trig = 1'b0;
    logic       alt_clk = 1'b0;
    logic       async_clk = 1'b0;
    logic [9:0] set_value = 10'h000;
    logic [9:0] ana_result;
    logic [4:0] ana_channel;
    logic       ana_enable, ana_sampling, ana_long_sample;
    logic       ana_low_power, ana_ten_bit, ana_clock_tick;
    logic [2:0] cfg_o;
    logic       en_q = 1'b0;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         starts = 0;
    int         smp_n = 0;

    acr_top acr_top_inst (
        .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .hardware_trigger_input(hw_trig),
        .alternate_clock(alt_clk), .internal_async_clock(async_clk),
        .ana_result(ana_result), .ana_enable(ana_enable),
        .ana_sampling(ana_sampling), .ana_channel(ana_channel),
        .ana_long_sample(ana_long_sample), .ana_low_power(ana_low_power),
        .ana_ten_bit(ana_ten_bit), .ana_clock_tick(ana_clock_tick)
    );
    acr_ana_model acr_ana_model_inst (
        .sys_clk(sys_clk), .ana_enable(ana_enable),
        .set_value(set_value), .ana_result(ana_result)
    );

    assign cfg_o = {ana_low_power, ana_long_sample, ana_ten_bit};

    ////////////////////////////////////////////////////////////////////////
    always #50 sys_clk = ~sys_clk;
    initial begin
        #30;
        forever #300 alt_clk = ~alt_clk;
    end
    initial begin
        #20;
        forever #200 async_clk = ~async_clk;
    end
    always @(posedge sys_clk) begin
        en_q <= ana_enable;
        if (ana_enable === 1'b1 && en_q !== 1'b1) starts <= starts + 1;
        if (ana_sampling === 1'b1) smp_n <= smp_n + 1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [9:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [2:0] a,
                      input logic [7:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        chk(nm, {2'b00, bus_rdata}, {2'b00, e});
    endtask
    task automatic conv(input logic [9:0] v);
        int n;
        n = 0;
        set_value = v;
        wr(3'h0, 8'h00);
        @(posedge sys_clk);
        while (ana_enable === 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic gap(input logic [7:0] cfg, input logic [9:0] e);
        int n;
        n = 0;
        wr(3'h6, cfg);
        wr(3'h0, 8'h00);
        while (ana_clock_tick !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ana_clock_tick !== 1'b1 && n < 100);
        chk("tick gap", 10'(n), e);
        wr(3'h0, 8'h1F);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int s;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rc("control one", 3'h0, 8'h1F);
        for (int i = 1; i < 8; i++) rc("reset value", 3'(i), 8'h00);
        wr(3'h1, 8'h70);
        rc("control two", 3'h1, 8'h70);
        wr(3'h1, 8'h00);
        wr(3'h5, 8'hA5);
        rc("cmp low", 3'h5, 8'hA5);
        wr(3'h4, 8'hFF);
        rc("cmp high", 3'h4, 8'h03);
        wr(3'h7, 8'h55);
        rc("unmapped", 3'h7, 8'h00);
        wr(3'h6, 8'h88);
        repeat (2) @(posedge sys_clk);
        chk("cfg out", 10'(cfg_o), 10'h005);
        wr(3'h6, 8'h14);
        repeat (2) @(posedge sys_clk);
        chk("cfg out", 10'(cfg_o), 10'h002);
        $display("test registers finished");
        for (int i = 0; i < 4; i++) gap(8'(i << 5), 10'(1 << i));
        gap(8'h01, 10'h002);
        gap(8'h02, 10'h006);
        gap(8'h03, 10'h004);
        $display("test clocks finished");
        wr(3'h6, 8'h10);
        s = smp_n;
        conv(10'h021);
        chk("long sample", 10'(smp_n - s), 10'h018);
        wr(3'h6, 8'h00);
        s = smp_n;
        conv(10'h033);
        chk("short sample", 10'(smp_n - s), 10'h004);
        rc("complete", 3'h0, 8'h80);
        rc("high 8", 3'h2, 8'h00);
        wr(3'h2, 8'hFF);
        rc("high ro", 3'h2, 8'h00);
        set_value = 10'h044;
        conv(10'h044);
        rc("low 8", 3'h3, 8'h44);
        rc("cleared", 3'h0, 8'h00);
        wr(3'h6, 8'h10);
        wr(3'h0, 8'h00);
        rc("active", 3'h1, 8'h80);
        wr(3'h0, 8'h1F);
        rc("aborted", 3'h1, 8'h00);
        chk("enable off", 10'(ana_enable), 10'h000);
        chk("channel off", 10'(ana_channel), 10'h01F);
        wr(3'h6, 8'h00);
        $display("test conversion finished");
        wr(3'h5, 8'h80);
        wr(3'h1, 8'h20);
        conv(10'h010);
        rc("cmp hit", 3'h3, 8'h10);
        conv(10'h090);
        rc("cmp miss flag", 3'h0, 8'h00);
        rc("cmp miss", 3'h3, 8'h10);
        wr(3'h1, 8'h30);
        conv(10'h080);
        rc("cmp ge", 3'h3, 8'h80);
        wr(3'h6, 8'h08);
        wr(3'h4, 8'h02);
        wr(3'h5, 8'h00);
        wr(3'h1, 8'h20);
        conv(10'h1FF);
        rc("cmp10 high", 3'h2, 8'h01);
        rc("cmp10 low", 3'h3, 8'hFF);
        conv(10'h200);
        rc("cmp10 keep", 3'h3, 8'hFF);
        wr(3'h1, 8'h00);
        $display("test compare finished");
        conv(10'h155);
        rc("lock high", 3'h2, 8'h01);
        conv(10'h2AA);
        rc("lock low", 3'h3, 8'h55);
        conv(10'h2AA);
        rc("new high", 3'h2, 8'h02);
        rc("new low", 3'h3, 8'hAA);
        $display("test interlock finished");
        wr(3'h6, 8'h00);
        wr(3'h1, 8'h40);
        s = starts;
        wr(3'h0, 8'h00);
        repeat (5) @(posedge sys_clk);
        chk("sw in hw mode", 10'(starts - s), 10'h000);
        set_value = 10'h05A;
        hw_trig <= 1'b1;
        repeat (200) @(posedge sys_clk);
        hw_trig <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("hw starts", 10'(starts - s), 10'h001);
        rc("hw result", 3'h3, 8'h5A);
        wr(3'h1, 8'h00);
        $display("test trigger finished");
        s = smp_n;
        wr(3'h0, 8'h20);
        repeat (30) @(posedge sys_clk);
        rc("continuous", 3'h1, 8'h80);
        wr(3'h0, 8'h3F);
        chk("restarts", 10'(smp_n - s), 10'h00C);
        rc("stopped", 3'h1, 8'h00);
        rc("cont result", 3'h3, 8'h5A);
        $display("test continuous finished");
        end_sim();
    end
endmodule
